// file: include/tximn_pkg.sv
package tximn_pkg;
  // =========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_MAINT = 8'h6C;
  localparam logic [7:0] IDX_TIMING = 8'h70;
  localparam logic [7:0] IDX_LB_CTRL = 8'h74;
  localparam logic [7:0] IDX_LB_PAT = 8'h75;
  localparam logic [7:0] IDX_RPT_CTRL = 8'h7F;
  localparam logic [7:0] IDX_BOM_CODE = 8'h80;
  localparam logic [7:0] IDX_STATUS = 8'h81;
  // =========================================================
  // field positions
  localparam int F_ALL_ONES = 0;
  localparam int F_ALL_ZEROS = 1;
  localparam int F_ALIGN_CHG = 2;
  localparam int F_CLK_SEL = 0;
  localparam int F_LB_EN = 2;
  localparam int F_LB_UNFR = 3;
  localparam int F_RPT_EN = 5;
  // =========================================================
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [5:0] BOM_IDLE = 6'h3F;
  // =========================================================
  // message framing
  localparam logic [7:0] OCT_FLAG = 8'h7E;
  localparam logic [5:0] OCT_SAPI_HI = 6'h0E;
  localparam logic [7:0] OCT_TEI = 8'h01;
  localparam logic [7:0] OCT_CTRL = 8'h03;
  localparam logic [7:0] OCT_LAST = 8'h01;
  localparam logic [6:0] BODY_LAST = 7'h67;
  localparam logic [6:0] FCS_LAST = 7'h0F;
  localparam logic [6:0] CRC_FIRST = 7'h08;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [8:0] CRC_SAT = 9'h1FF;
  localparam logic [14:0] BOM_PAT = 15'h7F00;
  localparam logic [3:0] BOM_LAST = 4'hE;
  localparam logic [3:0] LB_MIN_LEN = 4'h5;
  localparam int FRAMES_PER_SEC_DEF = 8000;
  // =========================================================
  // transmit clock sources
  localparam logic [1:0] SRC_LINE = 2'h0;
  localparam logic [1:0] SRC_BACKPLANE = 2'h1;
  localparam logic [1:0] SRC_MASTER = 2'h2;
  typedef struct packed {
    logic data;
    logic fbit;
    logic dl;
  } tximn_bit_t;
  typedef struct packed {
    logic lcv;
    logic crc;
    logic fbe;
    logic sfbe;
    logic slip;
  } tximn_evt_t;
  typedef enum logic [2:0] {
    RP_IDLE = 3'b001,
    RP_BODY = 3'b010,
    RP_FCS = 3'b100
  } tximn_rp_t;
endpackage

// file: core/tximn_core.sv
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module tximn_core import tximn_pkg::*; #(
  parameter int FRAMES_PER_SEC = FRAMES_PER_SEC_DEF
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // line configuration
  input wire logic t1_mode_in,
  input wire logic esf_mode_in,
  input wire logic tx_master_in,
  input wire logic tx_mux_in,
  input wire logic e1_rate_in,
  input wire logic clk_locked_in,
  // stream and events
  input wire logic bit_en_in,
  input wire tximn_bit_t bit_in,
  input wire tximn_evt_t evt_in,
  // stream out
  output logic data_out,
  output logic valid_out,
  // transmit timing
  output logic buf_sel_out,
  output logic [1:0] clk_src_out,
  output logic slip_out
);
  // the second counter is 14 bits wide
  if (FRAMES_PER_SEC < 2 || FRAMES_PER_SEC > 16384) begin : g_chk
    $error("FRAMES_PER_SEC must be 2 to 16384");
  end
  localparam logic [13:0] SEC_LAST = 14'(FRAMES_PER_SEC - 1);

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  // =========================================================
  // register bus
  logic [7:0] maint, timing, lb_ctrl, lb_pat, rpt_ctrl;
  logic [5:0] bom_code;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic addr_ok;
  logic take;
  logic [7:0] a_idx;
  logic [7:0] rd_val;
  logic rpt_busy, bom_on;
  logic [1:0] nmni;

  assign take = hsel_in && hready_in && htrans_in[1];
  assign a_idx = haddr_in[9:2];
  assign addr_ok = (haddr_in[31:10] == 22'h0) && (haddr_in[1:0] == 2'h0);

  always_comb begin
    case (a_idx)
      IDX_MAINT: rd_val = maint;
      IDX_TIMING: rd_val = timing;
      IDX_LB_CTRL: rd_val = lb_ctrl;
      IDX_LB_PAT: rd_val = lb_pat;
      IDX_RPT_CTRL: rd_val = rpt_ctrl;
      IDX_BOM_CODE: rd_val = {2'h0, bom_code};
      IDX_STATUS: rd_val = {3'h0, nmni, buf_sel_out, bom_on, rpt_busy};
      default: rd_val = RST_ZERO;
    endcase
    // a write in its data phase is forwarded to a read behind it
    if (wr_pend && wr_idx == a_idx && a_idx != IDX_STATUS) begin
      rd_val = hwdata_in[7:0];
    end
    if (!addr_ok) begin
      rd_val = RST_ZERO;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_pend <= 1'b0;
      wr_idx <= RST_ZERO;
      hrdata_out <= 32'h0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      wr_pend <= take && hwrite_in && addr_ok;
      wr_idx <= a_idx;
      if (take && !hwrite_in) begin
        hrdata_out <= {24'h0, rd_val};
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      maint <= RST_ZERO;
      timing <= RST_ZERO;
      lb_ctrl <= RST_ZERO;
      lb_pat <= RST_ZERO;
      rpt_ctrl <= RST_ZERO;
      bom_code <= BOM_IDLE;
    end else if (wr_pend) begin
      case (wr_idx)
        IDX_MAINT: maint <= hwdata_in[7:0];
        IDX_TIMING: timing <= hwdata_in[7:0];
        IDX_LB_CTRL: lb_ctrl <= hwdata_in[7:0];
        IDX_LB_PAT: lb_pat <= hwdata_in[7:0];
        IDX_RPT_CTRL: rpt_ctrl <= hwdata_in[7:0];
        IDX_BOM_CODE: bom_code <= hwdata_in[5:0];
        default: ;
      endcase
    end
  end

  // =========================================================
  // one-second interval and event counting
  logic esf_t1;
  logic frame_tick, sec_tick;
  logic [13:0] sec_cnt;
  logic [8:0] crc_cnt;
  logic [3:0] seen;
  logic [5:0] grd;
  logic [3:0] flg;
  logic [4:0] ctl;

  assign esf_t1 = t1_mode_in && esf_mode_in;
  assign frame_tick = bit_en_in && bit_in.fbit;
  assign sec_tick = frame_tick && sec_cnt == SEC_LAST;

  function automatic logic [5:0] grade(input logic [8:0] n);
    grade = {n > 9'd320, n > 9'd100 && n <= 9'd319,
             n > 9'd10 && n <= 9'd100, n > 9'd5 && n <= 9'd10,
             n > 9'd1 && n <= 9'd5, n == 9'd1};
  endfunction

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sec_cnt <= 14'h0;
    end else if (sec_tick) begin
      sec_cnt <= 14'h0;
    end else if (frame_tick) begin
      sec_cnt <= sec_cnt + 14'h1;
    end
  end

  // an event in the boundary cycle opens the next second's count
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      crc_cnt <= 9'h0;
      seen <= 4'h0;
    end else if (sec_tick) begin
      crc_cnt <= {8'h0, evt_in.crc};
      seen <= {evt_in.sfbe, evt_in.fbe, evt_in.lcv, evt_in.slip};
    end else begin
      if (evt_in.crc && crc_cnt != CRC_SAT) begin
        crc_cnt <= crc_cnt + 9'h1;
      end
      seen <= seen | {evt_in.sfbe, evt_in.fbe, evt_in.lcv, evt_in.slip};
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      grd <= 6'h0;
      flg <= 4'h0;
      ctl <= 5'h0;
    end else if (sec_tick && !rpt_busy) begin
      // held while a report is on the line so its octets stay coherent
      grd <= grade(crc_cnt);
      flg <= seen | {evt_in.sfbe, evt_in.fbe, evt_in.lcv, evt_in.slip};
      ctl <= rpt_ctrl[4:0];
    end
  end

  // =========================================================
  // performance report sender
  tximn_rp_t rp_state;
  logic [6:0] bitcnt;
  logic [15:0] crc;
  logic [7:0] oct_a, oct_b;
  logic [103:0] msg;
  logic dl_tick, rpt_bit, msg_bit;
  logic [1:0] rp_nm;

  assign dl_tick = bit_en_in && bit_in.fbit && bit_in.dl && esf_t1;
  // octet bit 8 on the left, so bit 1 leaves first
  assign oct_a = {grd[2], flg[1], grd[3], ctl[2], ctl[3], grd[4], flg[0],
                  grd[5]};
  assign oct_b = {flg[2], flg[3], ctl[4], grd[0], ctl[1], grd[1], rp_nm};
  assign msg = {OCT_LAST, {4{oct_b, oct_a}}, OCT_CTRL, OCT_TEI,
                OCT_SAPI_HI, ctl[0], 1'b0, OCT_FLAG};
  assign msg_bit = msg[bitcnt];
  assign rpt_bit = (rp_state == RP_FCS) ? ~crc[0] : msg_bit;
  assign rpt_busy = rp_state != RP_IDLE;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rp_state <= RP_IDLE;
      bitcnt <= 7'h0;
      crc <= CRC_INIT;
      nmni <= 2'h0;
      rp_nm <= 2'h0;
    end else if (!esf_t1) begin
      rp_state <= RP_IDLE;
    end else begin
      case (rp_state)
        RP_IDLE: begin
          if (sec_tick && rpt_ctrl[F_RPT_EN]) begin
            rp_state <= RP_BODY;
            bitcnt <= 7'h0;
            crc <= CRC_INIT;
            rp_nm <= nmni;
            nmni <= nmni + 2'h1;
          end
        end
        RP_BODY: begin
          if (dl_tick) begin
            if (bitcnt >= CRC_FIRST) begin
              crc <= (crc >> 1) ^ ((crc[0] ^ msg_bit) ? CRC_POLY : 16'h0);
            end
            bitcnt <= bitcnt + 7'h1;
            if (bitcnt == BODY_LAST) begin
              rp_state <= RP_FCS;
              bitcnt <= 7'h0;
            end
          end
        end
        RP_FCS: begin
          if (dl_tick) begin
            crc <= crc >> 1;
            bitcnt <= bitcnt + 7'h1;
            if (bitcnt == FCS_LAST) begin
              rp_state <= RP_IDLE;
            end
          end
        end
        default: rp_state <= RP_IDLE;
      endcase
    end
  end

  // =========================================================
  // bit-oriented message and loopback code
  logic [3:0] bom_idx;
  logic [14:0] bom_word;
  logic bom_bit;
  logic lb_on, lb_slot, lb_bit;
  logic [3:0] lb_len, lb_idx;

  assign bom_on = esf_t1 && bom_code != BOM_IDLE;
  assign bom_word = BOM_PAT | {8'h0, bom_code, 1'b0};
  assign bom_bit = bom_word[BOM_LAST - bom_idx];
  assign lb_on = t1_mode_in && lb_ctrl[F_LB_EN];
  assign lb_slot = !bit_in.fbit || lb_ctrl[F_LB_UNFR];
  assign lb_len = LB_MIN_LEN + {2'h0, lb_ctrl[1:0]};
  assign lb_bit = lb_pat[3'(lb_len - 4'h1 - lb_idx)];

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bom_idx <= 4'h0;
    end else if (!bom_on) begin
      bom_idx <= 4'h0;
    end else if (dl_tick && !rpt_busy) begin
      bom_idx <= (bom_idx == BOM_LAST) ? 4'h0 : bom_idx + 4'h1;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lb_idx <= 4'h0;
    end else if (!lb_on) begin
      lb_idx <= 4'h0;
    end else if (bit_en_in && lb_slot) begin
      lb_idx <= (lb_idx >= lb_len - 4'h1) ? 4'h0 : lb_idx + 4'h1;
    end
  end

  // =========================================================
  // output stage
  logic next_bit;
  logic fac_prev, del_pend, fac_tgl;

  assign fac_tgl = maint[F_ALIGN_CHG] != fac_prev;

  always_comb begin
    next_bit = bit_in.data;
    if (dl_tick && rpt_busy) begin
      next_bit = rpt_bit;
    end else if (dl_tick && bom_on) begin
      next_bit = bom_bit;
    end
    if (lb_on && lb_slot) begin
      next_bit = lb_bit;
    end
    if (maint[F_ALL_ONES]) begin
      next_bit = 1'b1;
    end
    if (maint[F_ALL_ZEROS]) begin
      next_bit = 1'b0;
    end
  end

  // deletion chosen over repetition: it needs no extra bit slot
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fac_prev <= 1'b0;
      del_pend <= 1'b0;
    end else begin
      fac_prev <= maint[F_ALIGN_CHG];
      // a toggle that meets a bit slot drops that very bit
      if (fac_tgl && !bit_en_in) begin
        del_pend <= 1'b1;
      end else if (bit_en_in) begin
        del_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_out <= 1'b0;
      valid_out <= 1'b0;
    end else begin
      valid_out <= bit_en_in && !del_pend && !fac_tgl;
      if (bit_en_in) begin
        data_out <= next_bit;
      end
    end
  end

  // =========================================================
  // transmit buffer and clock source
  logic tx_clock_source_sel;
  assign tx_clock_source_sel = timing[F_CLK_SEL];

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      buf_sel_out <= 1'b0;
      clk_src_out <= SRC_LINE;
      slip_out <= 1'b0;
    end else begin
      if (tx_master_in) begin
        buf_sel_out <= 1'b0;
        clk_src_out <= tx_clock_source_sel ? SRC_MASTER : SRC_LINE;
      end else if (t1_mode_in && e1_rate_in) begin
        buf_sel_out <= 1'b1;
        clk_src_out <= SRC_MASTER;
      end else begin
        // multiplexed mode falls through here like plain slave
        buf_sel_out <= tx_clock_source_sel;
        clk_src_out <= tx_clock_source_sel ? SRC_MASTER : SRC_BACKPLANE;
      end
      slip_out <= buf_sel_out && !clk_locked_in && frame_tick;
    end
  end

  // =========================================================
  // checks
  a_zero_prio: assert property (
    bit_en_in && maint[F_ALL_ZEROS] |=> !data_out)
    else $error("all zeros not applied");
  a_ones_fill: assert property (
    bit_en_in && maint[F_ALL_ONES] && !maint[F_ALL_ZEROS] |=> data_out)
    else $error("all ones not applied");
  a_bom_gate: assert property (
    dl_tick && !rpt_busy && bom_code == BOM_IDLE && !lb_on
    && !maint[F_ALL_ONES] && !maint[F_ALL_ZEROS] |=> data_out == $past(bit_in.data))
    else $error("suppressed bit message inserted");
  a_rpt_mode: assert property (
    $rose(rpt_busy) |-> $past(esf_t1 && sec_tick && rpt_ctrl[F_RPT_EN]))
    else $error("report started without cause");
  a_nm_step: assert property (
    $rose(rpt_busy) |-> nmni == $past(nmni) + 2'h1 && rp_nm == $past(nmni))
    else $error("modulo counter did not step");
  a_grade_one: assert property (
    sec_tick && crc_cnt == 9'd1 |=> grd == 6'h01)
    else $error("grade one not latched");
  a_sec_clear: assert property (
    sec_tick && !evt_in.crc |=> crc_cnt == 9'h0 ##1 sec_cnt <= 14'h1)
    else $error("second boundary did not clear");
  a_align_drop: assert property (
    bit_en_in && (fac_tgl || del_pend) |=> !valid_out)
    else $error("alignment change did not drop a bit");
  a_buf_master: assert property (
    tx_master_in |=> !buf_sel_out && clk_src_out != SRC_BACKPLANE)
    else $error("buffer used in master mode");
  a_buf_force: assert property (
    !tx_master_in && t1_mode_in && e1_rate_in |=> buf_sel_out)
    else $error("buffer not forced at backplane E1 rate");
  a_slave_sel: assert property (
    !tx_master_in && !e1_rate_in && !tx_clock_source_sel |=> clk_src_out == SRC_BACKPLANE)
    else $error("slave select zero not backplane");
endmodule // tximn_core

// file: verification/tximn_far_end.sv
`timescale 1ns/1ps
module tximn_far_end (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // line from the block
  input wire logic data_in,
  input wire logic valid_in,
  // tally
  output logic [15:0] rx_cnt_out
);
  // ==========================================
  // line receiver
  // a deleted bit is simply absent from the tally
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_cnt_out <= 16'h0000;
    end else if (valid_in) begin
      rx_cnt_out <= rx_cnt_out + 16'h0001;
    end
  end
endmodule // tximn_far_end

// file: verification/t1_tx_maintenance_insert_test.sv
`timescale 1ns/1ps
module t1_tx_maintenance_insert_test import tximn_pkg::*;;
  localparam int CN [8] = '{0, 1, 5, 6, 100, 101, 320, 321};
  // {master, mux, e1 rate, select, buffer, source}
  localparam logic [6:0] TT [8] = '{7'h40, 7'h4A, 7'h16, 7'h1E,
    7'h0E, 7'h01, 7'h2E, 7'h21};
  localparam logic [7:0] RI [6] = '{IDX_MAINT, IDX_TIMING,
    IDX_LB_CTRL, IDX_LB_PAT, IDX_RPT_CTRL, IDX_BOM_CODE};
  logic mclk_in, rstn_in, hsel, hwrite, t1, esf, master, mux, e1;
  logic locked, bit_en, data_o, valid_o, buf_sel, slip, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, clk_src;
  logic hreadyout;
  tximn_bit_t bit_v;
  tximn_evt_t evt;
  logic [15:0] rx_cnt, crc;
  logic [1:0] q [$];
  logic [1:0] n;
  logic [7:0] v, ctl, ev, oct [13];
  logic [5:0] g;
  logic [119:0] rb;
  logic fb;
  int error_cnt, cmp_count, pop_cnt, cyc, seed, ci, c, i, o, b, f;

  tximn_core #(.FRAMES_PER_SEC(4)) dut_u (.mclk_in(mclk_in),
    .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .t1_mode_in(t1),
    .esf_mode_in(esf), .tx_master_in(master), .tx_mux_in(mux),
    .e1_rate_in(e1), .clk_locked_in(locked), .bit_en_in(bit_en),
    .bit_in(bit_v), .evt_in(evt), .data_out(data_o),
    .valid_out(valid_o), .buf_sel_out(buf_sel),
    .clk_src_out(clk_src), .slip_out(slip));
  tximn_far_end far_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .data_in(data_o), .valid_in(valid_o), .rx_cnt_out(rx_cnt));

  // ==========================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] x,
      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, x, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk_in); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    logic [31:0] r;
    ahb(1'b1, x, {24'h0, d}, r);
  endtask
  task automatic rdc(input logic [7:0] x, input logic [7:0] m,
      input logic [7:0] e);
    logic [31:0] r;
    ahb(1'b0, x, 32'h0, r);
    chk(r[15:0] & {8'hFF, m}, {8'h00, e});
  endtask
  // mode: 0 ignore, 1 pass, 2 zero, 3 one, 4 deleted
  task automatic sb(input logic f_b, input logic dl, input int m);
    logic d;
    d = $random(seed);
    bit_en <= 1'b1;
    bit_v <= '{data: d, fbit: f_b, dl: dl};
    case (m)
      0: q.push_back(2'b00);
      1: q.push_back({1'b1, d});
      2: q.push_back(2'b10);
      3: q.push_back(2'b11);
      default: ;
    endcase
    @(posedge mclk_in);
  endtask
  task automatic run(input int k, input int mf, input int mo,
      input logic del);
    for (int j = 0; j < k; j++) begin
      sb(j % 4 == 0, 1'b0, (del && j == 0) ? 4 : ((j % 4 == 0) ? mf : mo));
    end
    bit_en <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk(16'(q.size()), 16'h0000);
  endtask
  task automatic do_reset;
    rstn_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    pop_cnt = 0;
    rstn_in <= 1'b1;
    @(posedge mclk_in);
  endtask

  // ==========================================
  // output watcher: settled values at the falling edge
  always @(negedge mclk_in) begin
    if (valid_o === 1'b1) begin
      pop_cnt++;
      if (q.size() == 0) begin
        chk(16'h0001, 16'h0000);
      end else begin
        n = q.pop_front();
        if (n[1]) chk({15'h0, data_o}, {15'h0, n[0]});
      end
    end
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run;
    end
  end
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  // ==========================================
  // main sequence
  initial begin
    seed = 94241;
    {rstn_in, hsel, hwrite, master, mux, e1, bit_en} = '0;
    {t1, esf, locked} = 3'b111;
    {haddr, hwdata, htrans, bit_v, evt} = '0;
    do_reset;
    foreach (RI[k]) rdc(RI[k], 8'hFF, RI[k] == IDX_BOM_CODE ? 8'h3F : 8'h00);
    foreach (RI[k]) begin
      v = $random(seed);
      if (RI[k] == IDX_BOM_CODE) v[7:6] = 2'b00;
      wr(RI[k], v);
      rdc(RI[k], 8'hFF, v);
    end
    wr(8'h40, 8'h5A);
    rdc(8'h40, 8'hFF, 8'h00);
    do_reset;
    foreach (TT[k]) begin
      master <= TT[k][6];
      mux <= TT[k][5];
      e1 <= TT[k][4];
      locked <= $random(seed);
      wr(IDX_TIMING, {7'h0, TT[k][3]});
      repeat (2) @(posedge mclk_in);
      #1 chk({13'h0, buf_sel, clk_src}, {13'h0, TT[k][2:0]});
    end
    {master, mux, e1} <= 3'b000;
    wr(IDX_MAINT, 8'h01);
    run(8, 3, 3, 1'b0);
    wr(IDX_MAINT, 8'h03);
    run(8, 2, 2, 1'b0);
    wr(IDX_MAINT, 8'h04);
    run(8, 1, 1, 1'b1);
    wr(IDX_MAINT, 8'h00);
    run(8, 1, 1, 1'b1);
    v = $random(seed) & 3;
    wr(IDX_LB_PAT, 8'hFF);
    wr(IDX_LB_CTRL, 8'h04 | v);
    run(16, 1, 3, 1'b0);
    wr(IDX_LB_CTRL, 8'h00);
    wr(IDX_LB_PAT, 8'h00);
    wr(IDX_LB_CTRL, 8'h0C | v);
    run(16, 2, 2, 1'b0);
    wr(IDX_LB_CTRL, 8'h08);
    run(8, 1, 1, 1'b0);
    rdc(IDX_STATUS, 8'h02, 8'h00);
    wr(IDX_BOM_CODE, 8'h15);
    rdc(IDX_STATUS, 8'h02, 8'h02);
    esf <= 1'b0;
    rdc(IDX_STATUS, 8'h02, 8'h00);
    esf <= 1'b1;
    // ==========================================
    // performance report after a clean reset
    do_reset;
    ctl = $random(seed);
    ev = $random(seed);
    ci = $random(seed) & 7;
    c = CN[ci];
    wr(IDX_RPT_CTRL, {3'b001, ctl[4:0]});
    for (i = 0; i < c || i == 0; i++) begin
      evt <= {ev[0] && i == 0, i < c, ev[1] && i == 0,
        ev[2] && i == 0, ev[3] && i == 0};
      @(posedge mclk_in);
    end
    evt <= '0;
    g = {c > 320, c > 100 && c <= 319, c > 10 && c <= 100,
      c > 5 && c <= 10, c > 1 && c <= 5, c == 1};
    oct[0] = 8'h7E;
    oct[1] = {6'h0E, ctl[0], 1'b0};
    oct[2] = 8'h01;
    oct[3] = 8'h03;
    for (o = 4; o < 12; o += 2) begin
      oct[o] = {g[2], ev[0], g[3], ctl[2], ctl[3], g[4], ev[3], g[5]};
      oct[o + 1] = {ev[1], ev[2], ctl[4], g[0], ctl[1], g[1], 2'b00};
    end
    oct[12] = 8'h01;
    crc = CRC_INIT;
    for (o = 1; o < 13; o++) begin
      for (b = 0; b < 8; b++) begin
        fb = crc[0] ^ oct[o][b];
        crc = crc >> 1;
        if (fb) crc = crc ^ CRC_POLY;
      end
      rb[(o - 1) * 8 +: 8] = oct[o - 1];
    end
    rb[96 +: 8] = oct[12];
    rb[104 +: 16] = ~crc;
    for (f = 0; f < 124; f++) begin
      sb(1'b1, 1'b1, f < 4 ? 0 : (rb[f - 4] ? 3 : 2));
      repeat (3) sb(1'b0, 1'b0, 1);
    end
    bit_en <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk(16'(q.size()), 16'h0000);
    chk(rx_cnt, 16'(pop_cnt));
    complete_run;
  end
endmodule // t1_tx_maintenance_insert_test
